// *** rtl/gpp_pkg.sv ***
// package of register offsets, reset values and variant codes for the gpio port block
// assumes an 8-bit cpu data-memory port with byte-wide address and single-cycle strobes
// ---------------------------------------------------------------
// Notes on behaviour
// - ports a to e, every line in and out
// - port registers sit at fixed memory addresses
// - input reads return live pins, unlatched
// - output latch holds until next write
// - pull-high only when input and enabled
// - port a per pin, b to d per nibble, e in two groups
// - port a pull-high bits, reset zero
// - grouped bit 6 drives port e 0,2,3
// - port e pin 1 never pulled high
// - grouped bit 1 drives upper port b
// - grouped bit 0 drives port b 0-3
// - unimplemented grouped bits read zero
// - mid variant adds port d nibble bits
// - large variant implements all eight grouped bits
// - bit 7 drives port e 4,5
// - direction 1 input, 0 cmos output
// - output pins read back the latch
// ---------------------------------------------------------------
package gpp_pkg;
	typedef enum logic [1:0] {gpp_small, gpp_mid, gpp_large} gpp_variant_t;
	// ---------------------------------------------------------------
	// register addresses
	// ---------------------------------------------------------------
	localparam logic [7:0] gpp_adr_pa_wake  = 8'h10;
	localparam logic [7:0] gpp_adr_pa_pull  = 8'h11;
	localparam logic [7:0] gpp_adr_pa_data  = 8'h12;
	localparam logic [7:0] gpp_adr_pa_dir   = 8'h13;
	localparam logic [7:0] gpp_adr_pa_edge  = 8'h14;
	localparam logic [7:0] gpp_adr_gx_wake  = 8'h15;
	localparam logic [7:0] gpp_adr_gx_pull  = 8'h16;
	localparam logic [7:0] gpp_adr_pa_fsl   = 8'h17;
	localparam logic [7:0] gpp_adr_pa_fsh   = 8'h18;
	localparam logic [7:0] gpp_adr_pb_data  = 8'h19;
	localparam logic [7:0] gpp_adr_pb_dir   = 8'h1a;
	localparam logic [7:0] gpp_adr_pc_data  = 8'h1b;
	localparam logic [7:0] gpp_adr_pc_dir   = 8'h1c;
	localparam logic [7:0] gpp_adr_pd_data  = 8'h1d;
	localparam logic [7:0] gpp_adr_pd_dir   = 8'h1e;
	localparam logic [7:0] gpp_adr_pe_data  = 8'h1f;
	localparam logic [7:0] gpp_adr_pe_dir   = 8'h20;
	// ---------------------------------------------------------------
	// reset values and grouped field positions
	// ---------------------------------------------------------------
	localparam logic [7:0] gpp_rst_zero     = 8'h00;
	localparam logic [7:0] gpp_rst_dir      = 8'hff;
	localparam logic [7:0] gpp_rst_latch    = 8'h00;
	localparam int         gpp_bit_pb_lo    = 0;
	localparam int         gpp_bit_pb_hi    = 1;
	localparam int         gpp_bit_pc_lo    = 2;
	localparam int         gpp_bit_pc_hi    = 3;
	localparam int         gpp_bit_pd_lo    = 4;
	localparam int         gpp_bit_pd_hi    = 5;
	localparam int         gpp_bit_pe_lo    = 6;
	localparam int         gpp_bit_pe_hi    = 7;
	localparam logic [7:0] gpp_grp_mask_sm  = 8'h43;
	localparam logic [7:0] gpp_grp_mask_md  = 8'h73;
	localparam logic [7:0] gpp_grp_mask_lg  = 8'hff;
	localparam int         gpp_sync_stages  = 2;
endpackage

// *** rtl/gpp_port.sv ***
// one port: data latch, direction register, pin drive and read-back mux
// assumes the parent decodes addresses into write strobes
`timescale 1ns/1ps
module gpp_port
#(
	parameter int W = 8
)
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         wr_data,
	input  wire logic         wr_dir,
	input  wire logic [7:0]   wdata,
	input  wire logic [W-1:0] pin_sync,
	input  wire logic [W-1:0] pull_en,
	output logic      [7:0]   rd_data,
	output logic      [7:0]   rd_dir,
	output logic      [W-1:0] pin_out,
	output logic      [W-1:0] pin_oe_n,
	output logic      [W-1:0] pull_on
);
	logic [W-1:0] latch_q;
	logic [W-1:0] dir_q;

	initial
	begin
		if (W < 1 || W > 8) $error("gpp_port width must be 1 to 8");
	end

	// latch changes only on its own write
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			latch_q <= gpp_pkg::gpp_rst_latch[W-1:0];
		else if (wr_data)
			latch_q <= wdata[W-1:0];
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			dir_q <= gpp_pkg::gpp_rst_dir[W-1:0];
		else if (wr_dir)
			dir_q <= wdata[W-1:0];
	end

	// drive outputs; pull applies only to inputs
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pin_out  <= '0;
			pin_oe_n <= '1;
			pull_on  <= '0;
		end
		else
		begin
			pin_out  <= latch_q;
			pin_oe_n <= dir_q;
			pull_on  <= dir_q & pull_en;
		end
	end

	// read mux: live pin for inputs, latch for outputs
	always_comb
	begin
		rd_data = 8'h00;
		rd_dir  = 8'h00;
		rd_data[W-1:0] = (dir_q & pin_sync) | (~dir_q & latch_q);
		rd_dir[W-1:0]  = dir_q;
	end
endmodule

// *** rtl/gpp_sync.sv ***
// two-stage synchroniser for a vector of pin levels
// assumes pins are asynchronous to clk
`timescale 1ns/1ps
module gpp_sync
#(
	parameter int W = 8
)
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	initial
	begin
		if (W < 1) $error("gpp_sync width must be positive");
	end

	// first stage feeds only the second
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			meta_q <= '0;
			q      <= '0;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// *** rtl/gpp_top.sv ***
// gpio port block top: register file on the cpu data-memory port and five ports
// assumes one-cycle rd/wr strobes with a byte address; read data valid next cycle
`timescale 1ns/1ps
module gpp_top
#(
	parameter gpp_pkg::gpp_variant_t VARIANT = gpp_pkg::gpp_large,
	parameter int PB_W = 8,
	parameter int PE_W = 6
)
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [7:0]   mem_addr,
	input  wire logic         mem_wr,
	input  wire logic         mem_rd,
	input  wire logic [7:0]   mem_wdata,
	output logic      [7:0]   mem_rdata,
	output logic              mem_hit,
	input  wire logic [7:0]   pa_in,
	output logic      [7:0]   pa_out,
	output logic      [7:0]   pa_oe_n,
	output logic      [7:0]   pa_pull,
	input  wire logic [PB_W-1:0] pb_in,
	output logic      [PB_W-1:0] pb_out,
	output logic      [PB_W-1:0] pb_oe_n,
	output logic      [PB_W-1:0] pb_pull,
	input  wire logic [7:0]   pc_in,
	output logic      [7:0]   pc_out,
	output logic      [7:0]   pc_oe_n,
	output logic      [7:0]   pc_pull,
	input  wire logic [7:0]   pd_in,
	output logic      [7:0]   pd_out,
	output logic      [7:0]   pd_oe_n,
	output logic      [7:0]   pd_pull,
	input  wire logic [PE_W-1:0] pe_in,
	output logic      [PE_W-1:0] pe_out,
	output logic      [PE_W-1:0] pe_oe_n,
	output logic      [PE_W-1:0] pe_pull,
	output logic      [7:0]   wake_en_a,
	output logic      [7:0]   wake_en_grp,
	output logic      [7:0]   wake_edge_a,
	output logic      [15:0]  func_sel_a
);
	localparam bit HAS_C = (VARIANT == gpp_pkg::gpp_large);
	localparam bit HAS_D = (VARIANT != gpp_pkg::gpp_small);
	localparam logic [7:0] GRP_MASK = (VARIANT == gpp_pkg::gpp_large) ? gpp_pkg::gpp_grp_mask_lg :
		(VARIANT == gpp_pkg::gpp_mid) ? gpp_pkg::gpp_grp_mask_md : gpp_pkg::gpp_grp_mask_sm;

	initial
	begin
		if (PB_W != 7 && PB_W != 8) $error("port b width must be 7 or 8");
		if (PE_W != 3 && PE_W != 6) $error("port e width must be 3 or 6");
		if (VARIANT == gpp_pkg::gpp_large && (PB_W != 8 || PE_W != 6)) $error("large variant needs 8/6");
		if (VARIANT != gpp_pkg::gpp_large && (PB_W != 7 || PE_W != 3)) $error("smaller variants need 7/3");
	end

	// ---------------------------------------------------------------
	// control registers
	// ---------------------------------------------------------------
	logic [7:0]  pa_pull_q;
	logic [7:0]  grp_pull_q;
	logic [7:0]  wake_a_q;
	logic [7:0]  wake_grp_q;
	logic [7:0]  edge_a_q;
	logic [7:0]  fsl_q;
	logic [7:0]  fsh_q;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			pa_pull_q <= gpp_pkg::gpp_rst_zero;
		else if (mem_wr && hit(mem_addr, gpp_pkg::gpp_adr_pa_pull))
			pa_pull_q <= mem_wdata;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			grp_pull_q <= gpp_pkg::gpp_rst_zero;
		else if (mem_wr && hit(mem_addr, gpp_pkg::gpp_adr_gx_pull))
			grp_pull_q <= mem_wdata & GRP_MASK;
	end

	// wake and function select are storage only here
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wake_a_q   <= gpp_pkg::gpp_rst_zero;
			wake_grp_q <= gpp_pkg::gpp_rst_zero;
			edge_a_q   <= gpp_pkg::gpp_rst_zero;
			fsl_q      <= gpp_pkg::gpp_rst_zero;
			fsh_q      <= gpp_pkg::gpp_rst_zero;
		end
		else if (mem_wr)
		begin
			if (hit(mem_addr, gpp_pkg::gpp_adr_pa_wake))
				wake_a_q <= mem_wdata;
			if (hit(mem_addr, gpp_pkg::gpp_adr_gx_wake))
				wake_grp_q <= mem_wdata & GRP_MASK;
			if (hit(mem_addr, gpp_pkg::gpp_adr_pa_edge))
				edge_a_q <= mem_wdata;
			if (hit(mem_addr, gpp_pkg::gpp_adr_pa_fsl))
				fsl_q <= mem_wdata;
			if (hit(mem_addr, gpp_pkg::gpp_adr_pa_fsh))
				fsh_q <= mem_wdata;
		end
	end

	// ---------------------------------------------------------------
	// pull-high expansion
	// ---------------------------------------------------------------
	logic [7:0] pb_pe_full;
	logic [7:0] pc_pe_full;
	logic [7:0] pd_pe_full;
	logic [5:0] pe_pe_full;

	function automatic logic [7:0] nib(input logic hi, input logic lo);
		nib = {{4{hi}}, {4{lo}}};
	endfunction

	always_comb
	begin
		pb_pe_full = nib(grp_pull_q[gpp_pkg::gpp_bit_pb_hi], grp_pull_q[gpp_pkg::gpp_bit_pb_lo]);
		pc_pe_full = nib(grp_pull_q[gpp_pkg::gpp_bit_pc_hi], grp_pull_q[gpp_pkg::gpp_bit_pc_lo]);
		pd_pe_full = nib(grp_pull_q[gpp_pkg::gpp_bit_pd_hi], grp_pull_q[gpp_pkg::gpp_bit_pd_lo]);
		pe_pe_full = {{2{grp_pull_q[gpp_pkg::gpp_bit_pe_hi]}}, {2{grp_pull_q[gpp_pkg::gpp_bit_pe_lo]}},
			1'b0, grp_pull_q[gpp_pkg::gpp_bit_pe_lo]};
	end

	// ---------------------------------------------------------------
	// ports
	// ---------------------------------------------------------------
	logic [7:0]      pa_s;
	logic [PB_W-1:0] pb_s;
	logic [7:0]      pc_s;
	logic [7:0]      pd_s;
	logic [PE_W-1:0] pe_s;
	logic [7:0]      rd_pa_d;
	logic [7:0]      rd_pa_c;
	logic [7:0]      rd_pb_d;
	logic [7:0]      rd_pb_c;
	logic [7:0]      rd_pc_d;
	logic [7:0]      rd_pc_c;
	logic [7:0]      rd_pd_d;
	logic [7:0]      rd_pd_c;
	logic [7:0]      rd_pe_d;
	logic [7:0]      rd_pe_c;
	logic [7:0]      pc_pull_raw;
	logic [7:0]      pd_pull_raw;

	gpp_sync #(.W(8))    u_sa (.clk(clk), .rst_n(rst_n), .d(pa_in), .q(pa_s));
	gpp_sync #(.W(PB_W)) u_sb (.clk(clk), .rst_n(rst_n), .d(pb_in), .q(pb_s));
	gpp_sync #(.W(8))    u_sc (.clk(clk), .rst_n(rst_n), .d(pc_in), .q(pc_s));
	gpp_sync #(.W(8))    u_sd (.clk(clk), .rst_n(rst_n), .d(pd_in), .q(pd_s));
	gpp_sync #(.W(PE_W)) u_se (.clk(clk), .rst_n(rst_n), .d(pe_in), .q(pe_s));

	// every port is a full bidirectional instance
	gpp_port #(.W(8)) u_pa (.clk(clk), .rst_n(rst_n),
		.wr_data(mem_wr && hit(mem_addr, gpp_pkg::gpp_adr_pa_data)),
		.wr_dir(mem_wr && hit(mem_addr, gpp_pkg::gpp_adr_pa_dir)),
		.wdata(mem_wdata), .pin_sync(pa_s), .pull_en(pa_pull_q),
		.rd_data(rd_pa_d), .rd_dir(rd_pa_c), .pin_out(pa_out), .pin_oe_n(pa_oe_n), .pull_on(pa_pull));
	gpp_port #(.W(PB_W)) u_pb (.clk(clk), .rst_n(rst_n),
		.wr_data(mem_wr && hit(mem_addr, gpp_pkg::gpp_adr_pb_data)),
		.wr_dir(mem_wr && hit(mem_addr, gpp_pkg::gpp_adr_pb_dir)),
		.wdata(mem_wdata), .pin_sync(pb_s), .pull_en(pb_pe_full[PB_W-1:0]),
		.rd_data(rd_pb_d), .rd_dir(rd_pb_c), .pin_out(pb_out), .pin_oe_n(pb_oe_n), .pull_on(pb_pull));
	gpp_port #(.W(8)) u_pc (.clk(clk), .rst_n(rst_n),
		.wr_data(HAS_C && mem_wr && hit(mem_addr, gpp_pkg::gpp_adr_pc_data)),
		.wr_dir(HAS_C && mem_wr && hit(mem_addr, gpp_pkg::gpp_adr_pc_dir)),
		.wdata(mem_wdata), .pin_sync(pc_s), .pull_en(pc_pe_full),
		.rd_data(rd_pc_d), .rd_dir(rd_pc_c), .pin_out(pc_out), .pin_oe_n(pc_oe_n), .pull_on(pc_pull_raw));
	gpp_port #(.W(8)) u_pd (.clk(clk), .rst_n(rst_n),
		.wr_data(HAS_D && mem_wr && hit(mem_addr, gpp_pkg::gpp_adr_pd_data)),
		.wr_dir(HAS_D && mem_wr && hit(mem_addr, gpp_pkg::gpp_adr_pd_dir)),
		.wdata(mem_wdata), .pin_sync(pd_s), .pull_en(pd_pe_full),
		.rd_data(rd_pd_d), .rd_dir(rd_pd_c), .pin_out(pd_out), .pin_oe_n(pd_oe_n), .pull_on(pd_pull_raw));
	gpp_port #(.W(PE_W)) u_pe (.clk(clk), .rst_n(rst_n),
		.wr_data(mem_wr && hit(mem_addr, gpp_pkg::gpp_adr_pe_data)),
		.wr_dir(mem_wr && hit(mem_addr, gpp_pkg::gpp_adr_pe_dir)),
		.wdata(mem_wdata), .pin_sync(pe_s), .pull_en(pe_pe_full[PE_W-1:0]),
		.rd_data(rd_pe_d), .rd_dir(rd_pe_c), .pin_out(pe_out), .pin_oe_n(pe_oe_n), .pull_on(pe_pull));

	// absent ports: grouped bits are masked to zero, so pulls stay off
	assign pc_pull = pc_pull_raw;
	assign pd_pull = pd_pull_raw;

	// ---------------------------------------------------------------
	// read path, registered; absent addresses answer zero with no hit
	// ---------------------------------------------------------------
	logic [7:0] rd_mux;
	logic       rd_ok;

	always_comb
	begin
		rd_mux = 8'h00;
		rd_ok  = 1'b1;
		case (mem_addr)
			gpp_pkg::gpp_adr_pa_wake: rd_mux = wake_a_q;
			gpp_pkg::gpp_adr_pa_pull: rd_mux = pa_pull_q;
			gpp_pkg::gpp_adr_pa_data: rd_mux = rd_pa_d;
			gpp_pkg::gpp_adr_pa_dir:  rd_mux = rd_pa_c;
			gpp_pkg::gpp_adr_pa_edge: rd_mux = edge_a_q;
			gpp_pkg::gpp_adr_gx_wake: rd_mux = wake_grp_q;
			gpp_pkg::gpp_adr_gx_pull: rd_mux = grp_pull_q & GRP_MASK;
			gpp_pkg::gpp_adr_pa_fsl:  rd_mux = fsl_q;
			gpp_pkg::gpp_adr_pa_fsh:  rd_mux = fsh_q;
			gpp_pkg::gpp_adr_pb_data: rd_mux = rd_pb_d;
			gpp_pkg::gpp_adr_pb_dir:  rd_mux = rd_pb_c;
			gpp_pkg::gpp_adr_pc_data: begin rd_mux = HAS_C ? rd_pc_d : 8'h00; rd_ok = HAS_C; end
			gpp_pkg::gpp_adr_pc_dir:  begin rd_mux = HAS_C ? rd_pc_c : 8'h00; rd_ok = HAS_C; end
			gpp_pkg::gpp_adr_pd_data: begin rd_mux = HAS_D ? rd_pd_d : 8'h00; rd_ok = HAS_D; end
			gpp_pkg::gpp_adr_pd_dir:  begin rd_mux = HAS_D ? rd_pd_c : 8'h00; rd_ok = HAS_D; end
			gpp_pkg::gpp_adr_pe_data: rd_mux = rd_pe_d;
			gpp_pkg::gpp_adr_pe_dir:  rd_mux = rd_pe_c;
			default:                  rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			mem_rdata <= 8'h00;
			mem_hit   <= 1'b0;
		end
		else
		begin
			mem_rdata <= mem_rd ? rd_mux : 8'h00;
			mem_hit   <= (mem_rd || mem_wr) && rd_ok;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wake_en_a   <= 8'h00;
			wake_en_grp <= 8'h00;
			wake_edge_a <= 8'h00;
			func_sel_a  <= 16'h0000;
		end
		else
		begin
			wake_en_a   <= wake_a_q;
			wake_en_grp <= wake_grp_q;
			wake_edge_a <= edge_a_q;
			func_sel_a  <= {fsh_q, fsl_q};
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_pe1_no_pull: assert property (@(posedge clk) disable iff (!rst_n) pe_pull[1] == 1'b0)
		else $error("port e pin 1 pulled high");
	a_pull_needs_input: assert property (@(posedge clk) disable iff (!rst_n) (pa_pull & ~pa_oe_n) == 8'h00)
		else $error("pull on an output pin");
	a_grp_masked: assert property (@(posedge clk) disable iff (!rst_n) (grp_pull_q & ~GRP_MASK) == 8'h00)
		else $error("unimplemented grouped bit set");
	a_pb_lo_pull: assert property (@(posedge clk) disable iff (!rst_n)
		(pb_oe_n[0] && $past(pb_oe_n[0]) && $past(grp_pull_q[0])) |-> pb_pull[0])
		else $error("port b low nibble pull missing");
	a_pa_latch_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!(mem_wr && mem_addr == gpp_pkg::gpp_adr_pa_data) |=> ##1 $stable(pa_out))
		else $error("port a latch changed without write");
	a_pa_read_back: assert property (@(posedge clk) disable iff (!rst_n)
		(mem_rd && mem_addr == gpp_pkg::gpp_adr_pa_data) |=> mem_rdata == $past(rd_pa_d))
		else $error("port a read data wrong");
	a_pa_pull_write: assert property (@(posedge clk) disable iff (!rst_n)
		(mem_wr && mem_addr == gpp_pkg::gpp_adr_pa_pull) |=> pa_pull_q == $past(mem_wdata))
		else $error("port a pull register not written");
	// upper port e pins exist only on the six-pin port
	if (PE_W == 6)
	begin : g_pe_hi
		a_pe_hi_pull: assert property (@(posedge clk) disable iff (!rst_n)
			grp_pull_q[gpp_pkg::gpp_bit_pe_hi] |=> pe_pull[5:4] == pe_oe_n[5:4])
			else $error("port e upper pull does not follow its enable");
	end
	a_pe_lo_pull: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(pe_pull[0]) |-> $past(grp_pull_q[6]))
		else $error("port e pin 0 pull without enable");
	a_pb_hi_pull: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(pb_pull[4]) |-> $past(grp_pull_q[1]))
		else $error("port b pin 4 pull without enable");
	a_pa_pull_pin: assert property (@(posedge clk) disable iff (!rst_n)
		pa_pull == ($past(pa_pull_q) & pa_oe_n))
		else $error("port a pull does not follow its own bit");
	a_grp_write: assert property (@(posedge clk) disable iff (!rst_n)
		(mem_wr && mem_addr == gpp_pkg::gpp_adr_gx_pull) |=> grp_pull_q == ($past(mem_wdata) & GRP_MASK))
		else $error("grouped pull register not written through mask");
	a_rd_idle_zero: assert property (@(posedge clk) disable iff (!rst_n)
		!mem_rd |=> mem_rdata == 8'h00)
		else $error("read data without a read strobe");
	a_absent_no_hit: assert property (@(posedge clk) disable iff (!rst_n)
		(!HAS_C && (mem_rd || mem_wr)
		&& (mem_addr == gpp_pkg::gpp_adr_pc_data || mem_addr == gpp_pkg::gpp_adr_pc_dir)) |=> !mem_hit)
		else $error("absent port c answered");
endmodule

// *** sim/gpp_pin_model.sv ***
// pin-side model of the switches and loads hung on one port
// assumes the port drives a pin while its oe_n bit is low
`timescale 1ns/1ps
module gpp_pin_model
#(
	parameter int W = 8
)
(
	input  wire logic         clk,
	input  wire logic [W-1:0] out,
	input  wire logic [W-1:0] oe_n,
	input  wire logic [W-1:0] pull,
	input  wire logic [W-1:0] sw_en,
	input  wire logic [W-1:0] sw_val,
	output logic      [W-1:0] pin
);
	logic [W-1:0] float_q = '0;

	// a line nobody drives or pulls has no level: toggle it so a stale value never passes
	always_ff @(posedge clk)
		float_q <= ~float_q;

	always_comb
	begin
		for (int i = 0; i < W; i++)
		begin
			if (oe_n[i] == 1'b0)
				pin[i] = out[i];
			else if (sw_en[i])
				pin[i] = sw_val[i];
			else if (pull[i])
				pin[i] = 1'b1;
			else
				pin[i] = float_q[i];
		end
	end
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the gpio port block, large variant, with a mid variant on the same bus
// assumes single-cycle strobes, read data one cycle after the strobe edge
`timescale 1ns/1ps
module testbench;
	logic            clk;
	logic            rst_n;
	logic [7:0]      mem_addr;
	logic            mem_wr;
	logic            mem_rd;
	logic [7:0]      mem_wdata;
	wire  [7:0]      mem_rdata;
	wire             mem_hit;
	wire  [7:0]      mid_rdata;
	wire             mid_hit;
	wire  [7:0]      wk_a;
	wire  [7:0]      wk_g;
	wire  [7:0]      wk_e;
	wire  [15:0]     fsel;
	logic [4:0][7:0] sw_en;
	logic [4:0][7:0] sw_val;
	wire  [4:0][7:0] pin;
	wire  [4:0][7:0] pout;
	wire  [4:0][7:0] poe;
	wire  [4:0][7:0] ppull;
	int              num_errors;
	int              num_checks;
	localparam logic [7:0] dat_adr [5] = '{gpp_pkg::gpp_adr_pa_data, gpp_pkg::gpp_adr_pb_data,
		gpp_pkg::gpp_adr_pc_data, gpp_pkg::gpp_adr_pd_data, gpp_pkg::gpp_adr_pe_data};
	localparam logic [7:0] dir_adr [5] = '{gpp_pkg::gpp_adr_pa_dir, gpp_pkg::gpp_adr_pb_dir,
		gpp_pkg::gpp_adr_pc_dir, gpp_pkg::gpp_adr_pd_dir, gpp_pkg::gpp_adr_pe_dir};
	localparam logic [7:0] st_adr [5] = '{gpp_pkg::gpp_adr_pa_wake, gpp_pkg::gpp_adr_gx_wake,
		gpp_pkg::gpp_adr_pa_edge, gpp_pkg::gpp_adr_pa_fsl, gpp_pkg::gpp_adr_pa_fsh};

	gpp_top i_gpp_top (.clk(clk), .rst_n(rst_n), .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_hit(mem_hit),
		.pa_in(pin[0]), .pa_out(pout[0]), .pa_oe_n(poe[0]), .pa_pull(ppull[0]),
		.pb_in(pin[1]), .pb_out(pout[1]), .pb_oe_n(poe[1]), .pb_pull(ppull[1]),
		.pc_in(pin[2]), .pc_out(pout[2]), .pc_oe_n(poe[2]), .pc_pull(ppull[2]),
		.pd_in(pin[3]), .pd_out(pout[3]), .pd_oe_n(poe[3]), .pd_pull(ppull[3]),
		.pe_in(pin[4][5:0]), .pe_out(pout[4][5:0]), .pe_oe_n(poe[4][5:0]), .pe_pull(ppull[4][5:0]),
		.wake_en_a(wk_a), .wake_en_grp(wk_g), .wake_edge_a(wk_e), .func_sel_a(fsel));

	// port e has six pins; the two spare model lines see an idle, undriven pin
	assign pout[4][7:6]  = 2'b00;
	assign poe[4][7:6]   = 2'b11;
	assign ppull[4][7:6] = 2'b00;

	// mid variant shares the bus so its masks and absent port c are seen
	gpp_top #(.VARIANT(gpp_pkg::gpp_mid), .PB_W(7), .PE_W(3)) i_gpp_top_mid (.clk(clk), .rst_n(rst_n),
		.mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata),
		.mem_rdata(mid_rdata), .mem_hit(mid_hit),
		.pa_in(pin[0]), .pa_out(), .pa_oe_n(), .pa_pull(),
		.pb_in(pin[1][6:0]), .pb_out(), .pb_oe_n(), .pb_pull(),
		.pc_in(pin[2]), .pc_out(), .pc_oe_n(), .pc_pull(),
		.pd_in(pin[3]), .pd_out(), .pd_oe_n(), .pd_pull(),
		.pe_in(pin[4][2:0]), .pe_out(), .pe_oe_n(), .pe_pull(),
		.wake_en_a(), .wake_en_grp(), .wake_edge_a(), .func_sel_a());

	for (genvar g = 0; g < 5; g++)
	begin : g_pin
		gpp_pin_model #(.W(8)) i_gpp_pin_model (.clk(clk), .out(pout[g]), .oe_n(poe[g]), .pull(ppull[g]),
			.sw_en(sw_en[g]), .sw_val(sw_val[g]), .pin(pin[g]));
	end

	always #20 clk = ~clk;

	// ---------------------------------------------------------------
	// expectations and bus tasks
	// ---------------------------------------------------------------
	function automatic logic [7:0] wmask(int p);
		return (p == 4) ? 8'h3f : 8'hff;
	endfunction

	function automatic logic [7:0] exp_pull(int p, logic [7:0] pa, logic [7:0] g);
		case (p)
			0: return pa;
			1: return {{4{g[1]}}, {4{g[0]}}};
			2: return {{4{g[3]}}, {4{g[2]}}};
			3: return {{4{g[5]}}, {4{g[4]}}};
			default: return {2'b00, g[7], g[7], g[6], g[6], 1'b0, g[6]};
		endcase
	endfunction

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// strobes stay up between back-to-back calls; reg_idle drops them
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		mem_rd = 1'b0;
		mem_wr = 1'b1;
		mem_addr = a;
		mem_wdata = d;
		@(negedge clk);
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		mem_wr = 1'b0;
		mem_rd = 1'b1;
		mem_addr = a;
		@(negedge clk);
		d = mem_rdata;
		chk({7'h00, mem_hit}, {7'h00, (a >= 8'h10 && a <= 8'h20)});
		chk({7'h00, mid_hit}, {7'h00, (a >= 8'h10 && a <= 8'h20 && a != gpp_pkg::gpp_adr_pc_data
			&& a != gpp_pkg::gpp_adr_pc_dir)});
	endtask

	task automatic reg_idle;
		mem_wr = 1'b0;
		mem_rd = 1'b0;
		repeat (4) @(negedge clk);
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		#(40 * 5000);
		num_errors++;
		finish_test();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		logic [7:0] rv;
		logic [7:0] port_a_pullhigh_enable;
		logic [7:0] grp;
		logic [7:0] ex;
		logic [7:0] dir [5];
		logic [7:0] dat [5];
		logic [7:0] pl [5];
		clk = 1'b0;
		rst_n = 1'b0;
		mem_addr = 8'h00;
		mem_wr = 1'b0;
		mem_rd = 1'b0;
		mem_wdata = 8'h00;
		sw_en = '1;
		sw_val = '0;
		num_errors = 0;
		num_checks = 0;
		void'($urandom(24550));
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		// every mapped place at its reset value, one unmapped place reads zero
		for (int a = 8'h10; a <= 8'h21; a++)
		begin
			reg_rd(8'(a), rv);
			ex = 8'h00;
			for (int p = 0; p < 5; p++)
				if (8'(a) == dir_adr[p])
					ex = 8'hff & wmask(p);
			if (8'(a) == gpp_pkg::gpp_adr_pe_data || 8'(a) == gpp_pkg::gpp_adr_pe_dir)
				rv = rv & 8'h3f;
			chk(rv, ex);
		end
		for (int p = 0; p < 5; p++)
			chk(ppull[p] & wmask(p), 8'h00);
		chk(wk_a | wk_g | wk_e | fsel[7:0] | fsel[15:8], 8'h00);
		// storage registers: write, read back, and see the copies on the outputs
		for (int k = 0; k < 5; k++)
		begin
			dat[k] = 8'($urandom());
			reg_wr(st_adr[k], dat[k]);
		end
		reg_idle();
		for (int k = 0; k < 5; k++)
		begin
			reg_rd(st_adr[k], rv);
			chk(rv, dat[k] & ((k == 1) ? gpp_pkg::gpp_grp_mask_lg : 8'hff));
		end
		chk(wk_a, dat[0]);
		chk(wk_g, dat[1] & gpp_pkg::gpp_grp_mask_lg);
		chk(wk_e, dat[2]);
		chk(fsel[7:0], dat[3]);
		chk(fsel[15:8], dat[4]);
		// first pass all outputs with every pull enabled, second all inputs left open except port e pin 1, which has no pull
		for (int i = 0; i < 24; i++)
		begin
			port_a_pullhigh_enable = (i < 2) ? 8'hff : 8'($urandom());
			grp = (i < 2) ? 8'hff : 8'($urandom());
			for (int p = 0; p < 5; p++)
			begin
				dir[p] = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom());
				dat[p] = 8'($urandom());
				pl[p] = exp_pull(p, port_a_pullhigh_enable, grp) & dir[p] & wmask(p);
				sw_val[p] = 8'($urandom());
				sw_en[p] = ~pl[p] | ((i == 1) ? 8'h00 : 8'($urandom()));
			end
			reg_wr(gpp_pkg::gpp_adr_pa_pull, port_a_pullhigh_enable);
			reg_wr(gpp_pkg::gpp_adr_gx_pull, grp);
			for (int p = 0; p < 5; p++)
			begin
				reg_wr(dat_adr[p], dat[p]);
				reg_wr(dir_adr[p], dir[p]);
			end
			reg_idle();
			reg_rd(gpp_pkg::gpp_adr_gx_pull, rv);
			chk(rv, grp);
			chk(mid_rdata, grp & gpp_pkg::gpp_grp_mask_md);
			reg_rd(gpp_pkg::gpp_adr_pa_pull, rv);
			chk(rv, port_a_pullhigh_enable);
			for (int p = 0; p < 5; p++)
			begin
				chk(pout[p] & wmask(p), dat[p] & wmask(p));
				chk(poe[p] & wmask(p), dir[p] & wmask(p));
				chk(ppull[p] & wmask(p), pl[p]);
				ex = ((dat[p] & ~dir[p]) | (((sw_en[p] & sw_val[p]) | (~sw_en[p] & pl[p])) & dir[p])) & wmask(p);
				reg_rd(dat_adr[p], rv);
				chk(rv & wmask(p), ex);
			end
			// turning every pin round must leave the latches untouched
			for (int p = 0; p < 5; p++)
				reg_wr(dir_adr[p], ~dir[p]);
			reg_idle();
			for (int p = 0; p < 5; p++)
			begin
				chk(pout[p] & wmask(p), dat[p] & wmask(p));
				chk(poe[p] & wmask(p), ~dir[p] & wmask(p));
			end
			sw_en = '1;
		end
		finish_test();
	end
endmodule
